// *** rtl/ssp_pkg.sv ***
// shared constants of the synchronous serial port
package ssp_pkg;
   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [1:0] ADDR_CTRL   = 2'h0;
   localparam logic [1:0] ADDR_STATUS = 2'h1;
   localparam logic [1:0] ADDR_TXDATA = 2'h2;
   localparam logic [1:0] ADDR_RXDATA = 2'h3;
   // ----------------------------------------------------------------
   // control fields
   // ----------------------------------------------------------------
   localparam int CTL_TX_ON     = 0;
   localparam int CTL_RX_ON     = 1;
   localparam int CTL_TXE_IE    = 2;
   localparam int CTL_TXD_IE    = 3;
   localparam int CTL_RX_IE     = 4;
   localparam int CTL_CKSRC_LO  = 5;
   localparam int CTL_CKSRC_HI  = 6;
   localparam int CTL_MSB_FIRST = 7;
   // ----------------------------------------------------------------
   // status fields
   // ----------------------------------------------------------------
   localparam int ST_TX_DONE = 2;
   localparam int ST_PARITY  = 3;
   localparam int ST_FRAME   = 4;
   localparam int ST_OVERRUN = 5;
   localparam int ST_RX_FULL = 6;
   localparam int ST_TX_EMPTY = 7;
   // ----------------------------------------------------------------
   // reset values and counts
   // ----------------------------------------------------------------
   localparam logic [7:0] CTRL_RST   = 8'h00;
   localparam logic [7:0] TXHOLD_RST = 8'h00;
   localparam logic [2:0] FIRST_CNT  = 3'h0;
   localparam logic [2:0] LAST_CNT   = 3'h7;
   localparam int CHAR_BITS    = 8;
   localparam int SCK_HALF_DEF = 4;
endpackage : ssp_pkg

// *** rtl/ssp_link_if.sv ***
// serial clock and data lines between the device and its peer
`timescale 1ns/100ps
interface ssp_link_if;
   logic devSck;
   logic devSckOe;
   logic devTxd;
   logic peerSck;
   logic peerSckOe;
   logic peerTxd;
   logic sck;

   // pulled high when nobody drives the clock
   assign sck = devSckOe ? devSck : (peerSckOe ? peerSck : 1'b1);

   modport dev (output devSck, output devSckOe, output devTxd,
                input sck, input peerTxd);
   modport peer (output peerSck, output peerSckOe, output peerTxd,
                 input sck, input devTxd);
endinterface : ssp_link_if

// *** rtl/ssp_peer_end.sv ***
// synchronous serial peer end
`timescale 1ns/100ps
module ssp_peer_end #(
   parameter int SCK_HALF = ssp_pkg::SCK_HALF_DEF
) (
   input  wire logic       ref_clk,
   input  wire logic       arst_n,
   ssp_link_if.peer        link,
   input  wire logic       driveClk,
   input  wire logic       msbFirst,
   input  wire logic [7:0] sendData,
   input  wire logic       sendLoad,
   input  wire logic       start,
   output      logic [7:0] recvData,
   output      logic       recvValid,
   output      logic       busy
);
   logic       sckMeta, sckSync, sckPrev, rxdMeta, rxdSync;
   logic       sckOut, sckOe, txdOut, run;
   logic [7:0] divCnt, txShift, rxShift;
   logic [2:0] cnt, pulseCnt;

   wire        tick    = divCnt == 8'(SCK_HALF - 1);
   wire        genRise = tick & ~sckOut;
   wire        genFall = tick & sckOut & run;
   wire        fallEv  = sckPrev & ~sckSync;
   wire        riseEv  = ~sckPrev & sckSync;
   wire [2:0]  idx     = msbFirst ? ssp_pkg::LAST_CNT - cnt : cnt;
   wire        lastBit = cnt == ssp_pkg::LAST_CNT;

   assign link.peerSck   = sckOut;
   assign link.peerSckOe = sckOe;
   assign link.peerTxd   = txdOut;

   // ----------------------------------------------------------------
   // line synchronisers
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         {sckMeta, sckSync, sckPrev} <= 3'h7;
         {rxdMeta, rxdSync}          <= 2'h3;
      end else begin
         {sckMeta, sckSync, sckPrev} <= {link.sck, sckMeta, sckSync};
         {rxdMeta, rxdSync}          <= {link.devTxd, rxdMeta};
      end
   end

   // ----------------------------------------------------------------
   // clock generator, eight pulses per start
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         divCnt   <= 8'h00;
         sckOut   <= 1'b1;
         sckOe    <= 1'b0;
         run      <= 1'b0;
         pulseCnt <= ssp_pkg::FIRST_CNT;
      end else begin
         sckOe  <= driveClk;
         divCnt <= (tick | ~(run | ~sckOut)) ? 8'h00 : divCnt + 8'h01;
         if (genFall | genRise)
            sckOut <= ~sckOut;
         if (genRise)
            pulseCnt <= pulseCnt + 3'h1;
         if (start & driveClk & ~run)
            run <= 1'b1;
         else if (genFall & pulseCnt == ssp_pkg::LAST_CNT)
            run <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // shifting on the observed line clock
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt       <= ssp_pkg::FIRST_CNT;
         txShift   <= 8'h00;
         rxShift   <= 8'h00;
         txdOut    <= 1'b1;
         recvData  <= 8'h00;
         recvValid <= 1'b0;
         busy      <= 1'b0;
      end else begin
         busy      <= run;
         recvValid <= riseEv & lastBit;
         if (sendLoad)
            txShift <= sendData;
         if (fallEv)
            txdOut <= txShift[idx];
         if (riseEv) begin
            rxShift[idx] <= rxdSync;
            cnt          <= cnt + 3'h1;
         end
         if (riseEv & lastBit) begin
            recvData      <= rxShift;
            recvData[idx] <= rxdSync;
         end
      end
   end
endmodule : ssp_peer_end

// *** rtl/ssp_dev_end.sv ***
// clocked synchronous serial unit, device end
`timescale 1ns/100ps
// Behaviour
// R01: characters are eight bits, no framing
// R02: transmit data changes on serial clock fall
// R03: receive data captured on serial clock rise
// R04: line keeps last bit after character
// R05: no parity or multiprocessor bit sent
// R06: independent double-buffered transmit and receive
// R07: source select chooses internal or external clock
// R08: eight pulses per character, idle high
// R09: transmit off forces buffer empty flag
// R10: receive off keeps receive flags, buffer
// R11: software disables both before reconfiguring
// R12: load shifter, set empty, request interrupt
// R13: shift with internal or external clock
// R14: check empty at MSB, chain without gap
// R15: empty at check sets done, holds lines; code keeps the internal clock running while receive is on and no error set
// R16: no transmit start while error flagged
// R17: DMA write clears empty flag automatically
// R18: receiver follows serial clock either direction
// R19: full at completion sets overrun, drops
// R20: good character to buffer, set full
// R21: errors block transfer until cleared
// R22: software enables both in one write
// R23: least significant bit first by default
module ssp_dev_end #(
   parameter int SCK_HALF = ssp_pkg::SCK_HALF_DEF
) (
   input  wire logic       ref_clk,
   input  wire logic       arst_n,
   ssp_link_if.dev         link,
   input  wire logic [1:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr,
   input  wire logic       rd,
   output      logic [7:0] rdata,
   input  wire logic       dmaWr,
   input  wire logic [7:0] dmaData,
   input  wire logic       dmaRd,
   output      logic [7:0] rxHoldingBuf,
   output      logic       txEmptyIrq,
   output      logic       txDoneIrq,
   output      logic       rxFullIrq,
   output      logic       rxErrorIrq
);
   logic [7:0] ctrl, txHoldingBuf, txShifter, rxShifter, divCnt;
   logic       txEmpty, txDone, rxFull, overrun, frameErr, parityErr;
   logic       sckMeta, sckSync, sckPrev, rxdMeta, rxdSync;
   logic       sckOut, sckOe, txdOut;
   logic       active, txSending, rxCapture, chainOk;
   logic [2:0] cnt;

   function automatic logic [7:0] put_bit(input logic [7:0] v,
                                          input logic [2:0] i,
                                          input logic       b);
      logic [7:0] r;
      r    = v;
      r[i] = b;
      return r;
   endfunction : put_bit

   // ----------------------------------------------------------------
   // register decode
   // ----------------------------------------------------------------
   wire ctrlWr = wr & addr == ssp_pkg::ADDR_CTRL;
   wire statWr = wr & addr == ssp_pkg::ADDR_STATUS;
   wire txWr   = (wr & addr == ssp_pkg::ADDR_TXDATA) | dmaWr;
   wire [7:0] txWdata = dmaWr ? dmaData : wdata;
   wire [7:0] status  = {txEmpty, rxFull, overrun, frameErr, parityErr,
                         txDone, 2'h0};
   wire [7:0] next_rdata =
      addr == ssp_pkg::ADDR_CTRL   ? ctrl :
      addr == ssp_pkg::ADDR_STATUS ? status :
      addr == ssp_pkg::ADDR_TXDATA ? txHoldingBuf : rxHoldingBuf;

   // ----------------------------------------------------------------
   // transfer control
   // ----------------------------------------------------------------
   wire internalClk = ~ctrl[ssp_pkg::CTL_CKSRC_HI];             // [R07]
   wire errs  = overrun | frameErr | parityErr;
   wire txGo  = ctrl[ssp_pkg::CTL_TX_ON] & ~txEmpty & ~errs;    // [R16]
   wire rxGo  = ctrl[ssp_pkg::CTL_RX_ON] & ~errs;               // [R21]
   wire startReq = txGo | rxGo;
   wire tick     = divCnt == 8'(SCK_HALF - 1);
   wire genRun   = active | startReq;
   wire genFall  = internalClk & genRun & tick & sckOut;         // [R08]
   wire genRise  = internalClk & tick & ~sckOut;
   wire extFall  = ~internalClk & sckPrev & ~sckSync;           // [R13]
   wire extRise  = ~internalClk & ~sckPrev & sckSync;
   wire fallEv   = genFall | extFall;
   wire riseEv   = genRise | extRise;
   wire [2:0] idx = ctrl[ssp_pkg::CTL_MSB_FIRST] ?
                    ssp_pkg::LAST_CNT - cnt : cnt;               // [R23]
   wire lastBit  = cnt == ssp_pkg::LAST_CNT;                     // [R01]
   wire startNow = fallEv & ~active & startReq;
   wire frameEnd = riseEv & active & lastBit;
   wire chainNow = frameEnd & txSending & chainOk;               // [R14]
   wire loadTx   = (startNow & txGo) | chainNow;                 // [R12]
   wire driveTx  = (startNow & txGo) | (fallEv & active & txSending); // [R04]
   wire [7:0] txSrc = startNow ? txHoldingBuf : txShifter;
   wire [7:0] rxNext = put_bit(rxShifter, idx, rxdSync);
   wire rxDone   = frameEnd & rxCapture;

   // ----------------------------------------------------------------
   // flag next values, set wins over clear
   // ----------------------------------------------------------------
   wire next_txEmpty = loadTx | ~ctrl[ssp_pkg::CTL_TX_ON] |     // [R09]
        (txEmpty & ~(statWr & ~wdata[ssp_pkg::ST_TX_EMPTY]) & ~dmaWr);
   wire next_txDone = (frameEnd & txSending & ~chainOk) |        // [R15]
        (txDone & ~loadTx & ~(statWr & ~wdata[ssp_pkg::ST_TX_DONE]));
   wire next_rxFull = (rxDone & ~rxFull) |                       // [R20]
        (rxFull & ~dmaRd & ~(statWr & ~wdata[ssp_pkg::ST_RX_FULL]));
   wire next_overrun = (rxDone & rxFull) |                       // [R19]
        (overrun & ~(statWr & ~wdata[ssp_pkg::ST_OVERRUN]));
   wire next_frameErr = frameErr & ~(statWr & ~wdata[ssp_pkg::ST_FRAME]);
   wire next_parityErr = parityErr &
        ~(statWr & ~wdata[ssp_pkg::ST_PARITY]);

   assign link.devSck   = sckOut;
   assign link.devSckOe = sckOe;
   assign link.devTxd   = txdOut;

   // ----------------------------------------------------------------
   // registers and flags
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl         <= ssp_pkg::CTRL_RST;
         txHoldingBuf <= ssp_pkg::TXHOLD_RST;
         rdata        <= 8'h00;
         {txEmpty, txDone} <= 2'h3;
         {rxFull, overrun, frameErr, parityErr} <= 4'h0;
      end else begin
         if (ctrlWr)
            ctrl <= wdata;                                       // [R22]
         if (txWr)
            txHoldingBuf <= txWdata;                             // [R06]
         if (rd)
            rdata <= next_rdata;
         txEmpty   <= next_txEmpty;                              // [R17]
         txDone    <= next_txDone;
         rxFull    <= next_rxFull;                               // [R10]
         overrun   <= next_overrun;
         frameErr  <= next_frameErr;
         parityErr <= next_parityErr;
      end
   end

   // ----------------------------------------------------------------
   // interrupt requests
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         {txEmptyIrq, txDoneIrq, rxFullIrq, rxErrorIrq} <= 4'h0;
      end else begin
         txEmptyIrq <= ctrl[ssp_pkg::CTL_TXE_IE] & txEmpty;      // [R12]
         txDoneIrq  <= ctrl[ssp_pkg::CTL_TXD_IE] & txDone;       // [R15]
         rxFullIrq  <= ctrl[ssp_pkg::CTL_RX_IE] & rxFull;        // [R20]
         rxErrorIrq <= ctrl[ssp_pkg::CTL_RX_IE] & errs;          // [R19]
      end
   end

   // ----------------------------------------------------------------
   // line synchronisers
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         {sckMeta, sckSync, sckPrev} <= 3'h7;
         {rxdMeta, rxdSync}          <= 2'h3;
      end else begin
         {sckMeta, sckSync, sckPrev} <= {link.sck, sckMeta, sckSync};
         {rxdMeta, rxdSync}          <= {link.peerTxd, rxdMeta}; // [R18]
      end
   end

   // ----------------------------------------------------------------
   // internal clock generator
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         divCnt <= 8'h00;
         sckOut <= 1'b1;
         sckOe  <= 1'b0;
      end else begin
         sckOe  <= internalClk;                                  // [R07]
         divCnt <= (tick | ~(genRun | ~sckOut) | ~internalClk) ?
                   8'h00 : divCnt + 8'h01;
         if (genFall | genRise)
            sckOut <= ~sckOut;                                   // [R08]
      end
   end

   // ----------------------------------------------------------------
   // frame sequencing and shifters
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         active    <= 1'b0;
         txSending <= 1'b0;
         rxCapture <= 1'b0;
         chainOk   <= 1'b0;
         cnt       <= ssp_pkg::FIRST_CNT;
      end else begin
         if (startNow) begin
            active    <= 1'b1;
            txSending <= txGo;
            rxCapture <= ctrl[ssp_pkg::CTL_RX_ON];
         end else if (chainNow) begin
            rxCapture <= ctrl[ssp_pkg::CTL_RX_ON];
         end else if (frameEnd) begin
            active    <= 1'b0;
            txSending <= 1'b0;
         end
         if (fallEv & active & lastBit)
            chainOk <= txGo;                                     // [R14]
         if (riseEv & active)
            cnt <= cnt + 3'h1;
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         txShifter    <= 8'h00;
         rxShifter    <= 8'h00;
         rxHoldingBuf <= 8'h00;
         txdOut       <= 1'b1;
      end else begin
         if (loadTx)
            txShifter <= txHoldingBuf;                           // [R06]
         if (driveTx)
            txdOut <= txSrc[idx];                                // [R02] [R05]
         if (riseEv & active)
            rxShifter <= rxNext;                                 // [R03]
         if (rxDone & ~rxFull)
            rxHoldingBuf <= rxNext;                              // [R20]
      end
   end
endmodule : ssp_dev_end

// *** test/ssp_checker.sv ***
// assertions on the serial link between the two ends
`timescale 1ns/100ps
module ssp_checker #(
   parameter int IDLE_GAP = 16
) (
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic devSck,
   input wire logic devSckOe,
   input wire logic devTxd,
   input wire logic peerSckOe,
   input wire logic sck
);
   // ----------------------------------------------------------------
   // idle and clock fall counting
   // ----------------------------------------------------------------
   logic       sckQ;
   logic [4:0] idleCnt;
   logic [4:0] fallCnt;
   wire        idleEdge = sck && (idleCnt == 5'(IDLE_GAP - 1));

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         sckQ    <= 1'b1;
         idleCnt <= 5'h00;
         fallCnt <= 5'h00;
      end else begin
         sckQ    <= sck;
         idleCnt <= !sck ? 5'h00 :
                    (idleCnt == 5'(IDLE_GAP)) ? idleCnt : idleCnt + 5'h01;
         fallCnt <= idleEdge ? 5'h00 :
                    (sckQ && !sck) ? fallCnt + 5'h01 : fallCnt;
      end
   end

   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);

   // phases of an internal clock with a half period of eight cycles
   sequence s_low;
      ##1 (!devSck) [*7] ##1 devSck;
   endsequence
   sequence s_high;
      ##1 devSck [*7];
   endsequence

   property p_txd_on_fall;
      devSckOe && $changed(devTxd) |-> $fell(devSck);
   endproperty
   property p_low_phase;
      devSckOe && $fell(devSck) |-> s_low;
   endproperty
   property p_high_phase;
      devSckOe && $rose(devSck) |-> s_high;
   endproperty
   property p_whole_chars;
      idleEdge |-> fallCnt[2:0] == 3'h0;
   endproperty
   property p_txd_rests;
      sck && idleCnt == 5'(IDLE_GAP) |-> $stable(devTxd);
   endproperty
   property p_one_driver;
      peerSckOe |-> !devSckOe;
   endproperty
   property p_ext_txd_low;
      !devSckOe && $changed(devTxd) |-> !sck;
   endproperty
   property p_sck_out;
      devSckOe |-> sck == devSck;
   endproperty

   a_txd_on_fall: assert property (p_txd_on_fall)
      else $error("transmit data moved off a clock fall");
   a_low_phase: assert property (p_low_phase)
      else $error("serial clock low phase has wrong length");
   a_high_phase: assert property (p_high_phase)
      else $error("serial clock high phase too short");
   a_whole_chars: assert property (p_whole_chars)
      else $error("clock pulses not a whole number of characters");
   a_txd_rests: assert property (p_txd_rests)
      else $error("transmit line moved while link idle");
   a_one_driver: assert property (p_one_driver)
      else $error("both ends drive the serial clock");
   a_ext_txd_low: assert property (p_ext_txd_low)
      else $error("transmit data moved while external clock high");
   a_sck_out: assert property (p_sck_out)
      else $error("internal clock not seen on the clock line");
endmodule : ssp_checker

// *** test/sync_serial_port_test.sv ***
// self-checking bench joining device end and peer end
`timescale 1ns/100ps
module sync_serial_port_test;
   localparam logic [1:0] aCtrl = ssp_pkg::ADDR_CTRL;
   localparam logic [1:0] aStat = ssp_pkg::ADDR_STATUS;
   localparam logic [1:0] aTx   = ssp_pkg::ADDR_TXDATA;
   localparam logic [1:0] aRx   = ssp_pkg::ADDR_RXDATA;
   logic       ref_clk  = 1'b0;
   logic       arst_n   = 1'b0;
   logic [1:0] addr     = 2'h0;
   logic [7:0] wdata    = 8'h00;
   logic       wr       = 1'b0;
   logic       rd       = 1'b0;
   logic       dmaWr    = 1'b0;
   logic       dmaRd    = 1'b0;
   logic [7:0] dmaData  = 8'h00;
   logic       driveClk = 1'b0;
   logic       msbFirst = 1'b0;
   logic [7:0] sendData = 8'h00;
   logic       sendLoad = 1'b0;
   logic       start    = 1'b0;
   logic [7:0] rdata, rxHoldingBuf, recvData, rv;
   logic       txEmptyIrq, txDoneIrq, rxFullIrq, rxErrorIrq;
   logic       recvValid, busy;
   logic [7:0] got[$];
   int         checked  = 0;
   int         failures = 0;

   always #10 ref_clk = ~ref_clk;

   ssp_link_if link ();
   ssp_dev_end #(.SCK_HALF(8)) ssp_dev_end_i (.ref_clk, .arst_n, .link,
      .addr, .wdata, .wr, .rd, .rdata, .dmaWr, .dmaData, .dmaRd,
      .rxHoldingBuf, .txEmptyIrq, .txDoneIrq, .rxFullIrq, .rxErrorIrq);
   ssp_peer_end #(.SCK_HALF(8)) ssp_peer_end_i (.ref_clk, .arst_n, .link,
      .driveClk, .msbFirst, .sendData, .sendLoad, .start, .recvData,
      .recvValid, .busy);
   ssp_checker ssp_checker_i (.ref_clk, .arst_n, .devSck(link.devSck),
      .devSckOe(link.devSckOe), .devTxd(link.devTxd),
      .peerSckOe(link.peerSckOe), .sck(link.sck));

   always @(posedge ref_clk) if (recvValid === 1'b1) got.push_back(recvData);

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected at %0t: seen %0h expected %0h",
                  $time, seen, exp);
      end
   endtask : check

   task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge ref_clk);
      wr <= 1'b0;
   endtask : wr_reg

   task automatic read_reg(input logic [1:0] a);
      @(posedge ref_clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge ref_clk);
      rd <= 1'b0;
      #1 rv = rdata;
   endtask : read_reg

   task automatic expect_reg(input logic [1:0] a, input logic [7:0] exp);
      read_reg(a);
      check(rv, exp);
   endtask : expect_reg

   // polls the done flag, bounded
   task automatic wait_done;
      int n = 0;
      repeat (20) @(posedge ref_clk);
      do begin
         read_reg(aStat);
         n++;
      end while (rv[ssp_pkg::ST_TX_DONE] !== 1'b1 && n < 1000);
      failures = failures + ((n >= 1000) ? 1 : 0);
      repeat (8) @(posedge ref_clk);
   endtask : wait_done

   task automatic report_and_stop;
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : report_and_stop

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_reset;
      expect_reg(aStat, 8'h84);
      expect_reg(aCtrl, ssp_pkg::CTRL_RST);
      check({7'h0, link.sck}, 8'h01);
   endtask : t_reset

   task automatic t_full_duplex;
      @(posedge ref_clk);
      sendData <= 8'h2B;
      sendLoad <= 1'b1;
      @(posedge ref_clk);
      sendLoad <= 1'b0;
      wr_reg(aCtrl, 8'h1F);
      wr_reg(aTx, 8'h1E);
      wr_reg(aStat, 8'h7F);
      repeat (10) @(posedge ref_clk);
      expect_reg(aStat, 8'h80);
      wr_reg(aTx, 8'hC8);
      wr_reg(aStat, 8'h7F);
      wait_done;
      check(got[0], 8'h1E);
      check(got[1], 8'hC8);
      expect_reg(aStat, 8'hE4);
      check(rxHoldingBuf, 8'h2B);
      check({4'h0, txEmptyIrq, txDoneIrq, rxFullIrq, rxErrorIrq},
            8'h0F);
      got.delete();
   endtask : t_full_duplex

   task automatic t_error_block;
      wr_reg(aCtrl, 8'h1D);
      expect_reg(aStat, 8'hE4);
      check(rxHoldingBuf, 8'h2B);
      wr_reg(aTx, 8'h11);
      wr_reg(aStat, 8'h7F);
      repeat (100) @(posedge ref_clk);
      expect_reg(aStat, 8'h64);
      check(8'(got.size()), 8'h00);
      @(posedge ref_clk);
      dmaRd <= 1'b1;
      @(posedge ref_clk);
      dmaRd <= 1'b0;
      wr_reg(aStat, 8'hDF);
      wait_done;
      check(got[0], 8'h11);
      expect_reg(aStat, 8'h84);
      got.delete();
   endtask : t_error_block

   task automatic t_tx_off;
      wr_reg(aCtrl, 8'h00);
      wr_reg(aTx, 8'h77);
      wr_reg(aStat, 8'h7F);
      expect_reg(aStat, 8'h84);
   endtask : t_tx_off

   task automatic t_dma;
      wr_reg(aCtrl, 8'h05);
      @(posedge ref_clk);
      dmaData <= 8'h36;
      dmaWr   <= 1'b1;
      @(posedge ref_clk);
      dmaWr <= 1'b0;
      wait_done;
      check(got[0], 8'h36);
      check({7'h0, txEmptyIrq}, 8'h01);
      got.delete();
   endtask : t_dma

   task automatic t_ext_msb;
      wr_reg(aCtrl, 8'h00);
      wr_reg(aCtrl, 8'hC0);
      wr_reg(aCtrl, 8'hC3);
      wr_reg(aTx, 8'h96);
      wr_reg(aStat, 8'h7F);
      @(posedge ref_clk);
      msbFirst <= 1'b1;
      driveClk <= 1'b1;
      sendData <= 8'h4D;
      sendLoad <= 1'b1;
      @(posedge ref_clk);
      sendLoad <= 1'b0;
      start    <= 1'b1;
      @(posedge ref_clk);
      start <= 1'b0;
      repeat (4) @(posedge ref_clk);
      check({7'h0, busy}, 8'h01);
      wait_done;
      check({7'h0, busy}, 8'h00);
      check(got[0], 8'h96);
      expect_reg(aRx, 8'h4D);
      expect_reg(aStat, 8'hC4);
   endtask : t_ext_msb

   // ----------------------------------------------------------------
   // main sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      repeat (4) @(posedge ref_clk);
      arst_n <= 1'b1;
      t_reset;
      t_full_duplex;
      t_error_block;
      t_tx_off;
      t_dma;
      t_ext_msb;
      report_and_stop;
   end

   initial begin
      repeat (20000) @(posedge ref_clk);
      failures++;
      report_and_stop;
   end
endmodule : sync_serial_port_test
